/* rtl/nv_ctrl_pkg.sv */
package nv_ctrl_pkg;
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 8;
  localparam int          ARRAY_WORDS   = 8192;
  localparam int          ARRAY_AW      = 13;
  localparam int          USER_BYTES    = 7680;
  localparam int          VECTOR_BYTES  = 36;
  localparam int          PAGE_BYTES    = 64;
  localparam int          ROW_BYTES     = 32;
  localparam int          PAGE_SHIFT    = 6;
  localparam int          ROW_SHIFT     = 5;
  localparam logic [15:0] ARRAY_BASE    = 16'hE000;
  localparam logic [15:0] USER_BASE     = 16'hE000 + 16'(8192 - 7680 - 36 - 1) * 16'h0000;
  localparam logic [15:0] TEST_CTRL_ADDR = 16'hFE07;
  localparam logic [15:0] OP_CTRL_ADDR  = 16'hFE08;
  localparam logic [15:0] PROTECT_ADDR  = 16'hFF7E;
  localparam logic [15:0] VECTOR_BASE   = 16'hFFDC;
  localparam logic [15:0] RESET_VECTOR  = 16'hFFFE;
  localparam logic [15:0] SECURE_KEY_ADDR = 16'hFE0F;
  localparam int          HIGH_VOLTAGE_ENABLE_BIT      = 3;
  localparam int          MARGIN_BIT    = 2;
  localparam int          ERASE_BIT     = 1;
  localparam int          PROG_BIT      = 0;
  localparam logic [7:0]  OP_CTRL_RST   = 8'h00;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  localparam logic [7:0]  SECURE_READ   = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;
  localparam int          CLK_MHZ       = 100;
  localparam int          T_NVS_US      = 10;
  localparam int          T_NVS_CYC     = T_NVS_US * CLK_MHZ;
  localparam int          CNT_W         = 12;
endpackage

/* rtl/nv_array_store.sv */
`timescale 1ns/1ns
// byte-wide storage: writes AND in zeros (program), page erase sets 64 bytes to ones
module nv_array_store #(
  parameter int AW    = nv_ctrl_pkg::ARRAY_AW,
  parameter int DW    = nv_ctrl_pkg::DATA_W,
  parameter int PSH   = nv_ctrl_pkg::PAGE_SHIFT
) (
  input  wire logic          clk_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic          prog_i,
  input  wire logic [DW-1:0] prog_data_i,
  input  wire logic          erase_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];
  logic [AW-PSH-1:0] erase_page;

  assign erase_page = addr_i[AW-1:PSH];

  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = nv_ctrl_pkg::ERASED_BYTE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (erase_i) begin
      for (int i = 0; i < 2**PSH; i++) begin
        mem[{erase_page, PSH'(i)}] <= nv_ctrl_pkg::ERASED_BYTE;
      end
    end else if (prog_i) begin
      mem[addr_i] <= mem[addr_i] & prog_data_i;
    end
  end

  // combinational read so the controller registers the chosen byte only once
  assign rdata_o = mem[addr_i];
endmodule

/* rtl/nv_protect_check.sv */
`timescale 1ns/1ns
// target is protected when it lies at or above the start derived from the protect byte
module nv_protect_check (
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  protect_i,
  output logic             protected_o
);
  logic [15:0] start;
  // protect byte gives bits 13:6 of the start; all ones means nothing protected
  assign start = {2'b11, protect_i, 6'h00};
  assign protected_o = (protect_i != nv_ctrl_pkg::ERASED_BYTE) && (addr_i >= start);
endmodule

/* rtl/nv_ctrl.sv */
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
// Function
// [R1] The array holds 7,680 user bytes, 36 vector bytes and one protect byte.
// [R2] Erased bits read as one and programmed bits read as zero.
// [R3] Storage is 8192 bytes, erased by page and programmed by byte.
// [R4] An erase page is 64 bytes aligned to 64.
// [R5] Page erase sets every byte of the page to ones and nothing else.
// [R6] A page is two adjacent program rows erased together.
// [R7] A security lock stops reads of the array contents; the code still returns the protect byte when secured.
// [R8] The control register holds high voltage, margin, erase and program in bits 3..0.
// [R9] The protect byte lives in the array and survives reset.
// [R10] Vectors sit from the vector base to the top, high byte first, reset vector last.
// [R11] Erase and program select may never be one together.
// [R12] High voltage sets only with a select and the preceding sequence steps done.
// [R13] High voltage is refused when the target lies in the protected range.
// [R14] Row programming latches addresses only within one aligned 32-byte row.
// [R15] With no select active, array reads return data and alter nothing.
module nv_ctrl (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        secure_i,
  output logic      [7:0]  rdata_o,
  output logic             high_voltage_o
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // secure strap synchroniser
  // ---------------------------------------------------------------
  logic sec_meta_reg;
  logic sec_reg;

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sec_meta_reg <= 1'b1;
      sec_reg      <= 1'b1;
    end else begin
      sec_meta_reg <= secure_i;
      sec_reg      <= sec_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // user bytes, protect byte and vectors; register holes read as unmapped
  function automatic logic in_array(input logic [15:0] a);
    logic [15:0] user_end;
    user_end = nv_ctrl_pkg::ARRAY_BASE + 16'(nv_ctrl_pkg::USER_BYTES);
    return (a >= nv_ctrl_pkg::ARRAY_BASE && a < user_end)
           || a == nv_ctrl_pkg::PROTECT_ADDR
           || a >= nv_ctrl_pkg::VECTOR_BASE;
  endfunction

  logic in_arr;
  logic hit_ctrl;
  logic hit_test;
  logic hit_prot;
  logic [nv_ctrl_pkg::ARRAY_AW-1:0] arr_addr;

  assign in_arr   = in_array(addr_i);  // [R1] [R3]
  assign hit_ctrl = addr_i == nv_ctrl_pkg::OP_CTRL_ADDR;
  assign hit_test = addr_i == nv_ctrl_pkg::TEST_CTRL_ADDR;
  assign hit_prot = addr_i == nv_ctrl_pkg::PROTECT_ADDR;
  assign arr_addr = addr_i[nv_ctrl_pkg::ARRAY_AW-1:0];

  // ---------------------------------------------------------------
  // control and sequence state
  // ---------------------------------------------------------------
  typedef enum {SQ_IDLE, SQ_SEL, SQ_PROT_READ, SQ_LATCHED, SQ_ARMED} seq_t;

  logic [3:0]  ctrl_reg,  ctrl_next;
  seq_t        seq_reg,   seq_next;
  logic [15:0] tgt_reg,   tgt_next;
  logic [nv_ctrl_pkg::CNT_W-1:0] nvs_reg, nvs_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        arr_rd_hit;
  logic        sec_rd_hit;
  logic        do_prog;
  logic        do_erase;
  logic        tgt_prot;
  logic [7:0]  arr_q;
  logic [7:0]  prot_byte;
  logic        ers;
  logic        prg;
  logic        hv;

  assign ers = ctrl_reg[nv_ctrl_pkg::ERASE_BIT];
  assign prg = ctrl_reg[nv_ctrl_pkg::PROG_BIT];
  assign hv  = ctrl_reg[nv_ctrl_pkg::HIGH_VOLTAGE_ENABLE_BIT];

  nv_protect_check u_prot (
    .addr_i      (tgt_reg),
    .protect_i   (prot_byte),
    .protected_o (tgt_prot)
  );

  always_comb begin
    ctrl_next   = ctrl_reg;
    seq_next    = seq_reg;
    tgt_next    = tgt_reg;
    nvs_next    = nvs_reg;
    arr_rd_hit  = 1'b0;
    sec_rd_hit  = 1'b0;
    do_prog     = 1'b0;
    do_erase    = 1'b0;
    if (nvs_reg != '0) begin
      nvs_next = nvs_reg - 1'b1;
    end
    if (!ers && !prg) begin
      seq_next = SQ_IDLE;
    end
    if (wr_i && hit_ctrl) begin
      if (!(wdata_i[nv_ctrl_pkg::ERASE_BIT] && wdata_i[nv_ctrl_pkg::PROG_BIT])) begin  // [R11]
        ctrl_next[nv_ctrl_pkg::ERASE_BIT:nv_ctrl_pkg::PROG_BIT] =
          wdata_i[nv_ctrl_pkg::ERASE_BIT:nv_ctrl_pkg::PROG_BIT];
        ctrl_next[nv_ctrl_pkg::MARGIN_BIT] = wdata_i[nv_ctrl_pkg::MARGIN_BIT];
        if ((wdata_i[nv_ctrl_pkg::ERASE_BIT] || wdata_i[nv_ctrl_pkg::PROG_BIT])
            && seq_reg == SQ_IDLE) begin
          seq_next = SQ_SEL;
        end
      end
      if (wdata_i[nv_ctrl_pkg::HIGH_VOLTAGE_ENABLE_BIT]) begin
        // no countdown left, sequence walked, target unprotected
        if ((ers || prg) && seq_reg == SQ_LATCHED && nvs_reg == '0  // [R12]
            && !tgt_prot) begin  // [R13]
          ctrl_next[nv_ctrl_pkg::HIGH_VOLTAGE_ENABLE_BIT] = 1'b1;
          seq_next = SQ_ARMED;
        end
      end else begin
        ctrl_next[nv_ctrl_pkg::HIGH_VOLTAGE_ENABLE_BIT] = 1'b0;
      end
    end
    if (rd_i && hit_prot && seq_reg == SQ_SEL) begin
      seq_next = SQ_PROT_READ;
    end
    if (wr_i && in_arr) begin
      if (seq_reg == SQ_PROT_READ) begin
        tgt_next = addr_i;
        nvs_next = nv_ctrl_pkg::CNT_W'(nv_ctrl_pkg::T_NVS_CYC);
        seq_next = SQ_LATCHED;
      end else if (seq_reg == SQ_ARMED && prg && hv
                   && addr_i[15:nv_ctrl_pkg::ROW_SHIFT] == tgt_reg[15:nv_ctrl_pkg::ROW_SHIFT]) begin
        do_prog = 1'b1;  // [R14] [R3]
      end
    end
    // erase fires once when voltage rises on an erase selection
    if (seq_reg == SQ_ARMED && seq_next == SQ_ARMED && ers && hv && nvs_reg == '0
        && tgt_reg != '0) begin
      do_erase = 1'b1;  // [R5] [R6] [R4]
      tgt_next = '0;
    end
    if (rd_i && in_arr) begin
      if (sec_reg && !hit_prot) begin
        sec_rd_hit = 1'b1;  // [R7]
      end else begin
        arr_rd_hit = 1'b1;  // [R15]
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg   <= nv_ctrl_pkg::OP_CTRL_RST[3:0];  // [R8]
      seq_reg    <= SQ_IDLE;
      tgt_reg    <= '0;
      nvs_reg    <= '0;
    end else begin
      ctrl_reg   <= ctrl_next;
      seq_reg    <= seq_next;
      tgt_reg    <= tgt_next;
      nvs_reg    <= nvs_next;
    end
  end

  // ---------------------------------------------------------------
  // array (protect byte and vectors live here, so reset never touches them)
  // ---------------------------------------------------------------
  logic [nv_ctrl_pkg::ARRAY_AW-1:0] store_addr;
  assign store_addr = do_erase ? tgt_reg[nv_ctrl_pkg::ARRAY_AW-1:0] : arr_addr;

  nv_array_store u_store (
    .clk_i       (clk_i),
    .addr_i      (store_addr),
    .prog_i      (do_prog),
    .prog_data_i (wdata_i),
    .erase_i     (do_erase),
    .rdata_o     (arr_q)
  );  // [R2] [R9] [R10]

  // protect byte shadow, captured by the protect read that follows the select write
  logic [7:0] prot_reg, prot_next;
  assign prot_byte = prot_reg;

  always_comb begin
    prot_next = prot_reg;
    if (rd_i && hit_prot && seq_reg == SQ_SEL) begin
      prot_next = arr_q;  // [R9]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prot_reg <= nv_ctrl_pkg::ERASED_BYTE;
    end else begin
      prot_reg <= prot_next;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic       ctrl_rd_hit;
  logic       hv_out_reg;

  assign ctrl_rd_hit = rd_i && hit_ctrl;

  // byte chosen in the strobe cycle and registered: it stands one cycle only
  always_comb begin
    rdata_next = nv_ctrl_pkg::UNMAPPED_READ;
    if (ctrl_rd_hit) begin
      rdata_next = {4'h0, ctrl_reg};  // [R8]
    end else if (arr_rd_hit) begin
      rdata_next = arr_q;  // [R2]
    end else if (sec_rd_hit) begin
      rdata_next = nv_ctrl_pkg::SECURE_READ;  // [R7]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg  <= nv_ctrl_pkg::UNMAPPED_READ;
      hv_out_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      hv_out_reg <= ctrl_next[nv_ctrl_pkg::HIGH_VOLTAGE_ENABLE_BIT];
    end
  end

  assign rdata_o        = rdata_reg;
  assign high_voltage_o = hv_out_reg;
endmodule

/* tb/nv_ctrl_props.sv */
`timescale 1ns/1ns
module nv_ctrl_props (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic        secure_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        high_voltage_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic ctl_rd;
  logic arr_rd;
  logic hv_wr;
  assign ctl_rd = rd_i && addr_i == 16'hFE08;
  assign arr_rd = rd_i && addr_i >= 16'hE000 && addr_i < 16'hFE00;
  assign hv_wr = wr_i && addr_i == 16'hFE08 && wdata_i[3];
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_ctrl_upper: assert property (ctl_rd |=> rdata_o[7:4] == 4'h0)
    else $error("control upper bits not zero");
  a_sel_interlock: assert property (ctl_rd |=> !(rdata_o[1] && rdata_o[0]))
    else $error("erase and program select both set");
  a_hv_cause: assert property ($rose(high_voltage_o) |-> $past(hv_wr) || $past(hv_wr, 2))
    else $error("high voltage rose without a control write");
  a_test_zero: assert property (rd_i && addr_i == 16'hFE07 |=> rdata_o == 8'h00)
    else $error("test control not zero");
  a_secure_blk: assert property (secure_i [*4] ##0 arr_rd |=> rdata_o == 8'h00)
    else $error("secured array read returned data");
  a_unmapped: assert property (rd_i && addr_i < 16'hE000 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_hv_cleared: assert property (wr_i && addr_i == 16'hFE08 && !wdata_i[3]
    && !(wdata_i[1] && wdata_i[0]) |-> ##[1:2] !high_voltage_o)
    else $error("high voltage not cleared");
  cover property ($rose(high_voltage_o));
  cover property (secure_i [*4] ##0 arr_rd);
  cover property (ctl_rd);
endmodule

/* tb/cpu_model.sv */
`timescale 1ns/1ns
module cpu_model (
  input  wire logic        clk_i,
  input  wire logic [7:0]  rdata_i,
  output logic      [15:0] addr_o,
  output logic      [7:0]  wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial begin
    addr_o = 16'h0000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // released bus shows inverted values so stale data never passes
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    // data stands only until the next edge, so take it mid-cycle
    @(negedge clk_i);
    d = rdata_i;
    @(posedge clk_i);
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ns
module tb;
  logic        clk;
  logic        arst_n;
  logic        secure;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        hv;
  logic [7:0]  v;
  int          bad_count = 0;
  int          checks = 0;
  nv_ctrl nv_ctrl_inst (.clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .secure_i(secure), .rdata_o(rdata), .high_voltage_o(hv));
  cpu_model cpu_model_inst (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    cpu_model_inst.rd(a, v);
    chk($sformatf("read %h", a), e, v);
  endtask
  task automatic hchk(input logic e);
    repeat (2) @(posedge clk);
    chk("high voltage", {7'h00, e}, {7'h00, hv});
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // select, protect read, latch write, setup wait, then high voltage
  task automatic nv_seq(input logic [7:0] sel, input logic [15:0] la);
    cpu_model_inst.wr(16'hFE08, sel);
    cpu_model_inst.rd(16'hFF7E, v);
    cpu_model_inst.wr(la, 8'hFF);
    repeat (nv_ctrl_pkg::T_NVS_CYC) @(posedge clk);
    cpu_model_inst.wr(16'hFE08, sel | 8'h08);
  endtask
  task automatic finish_op();
    cpu_model_inst.wr(16'hFE08, 8'h08);
    cpu_model_inst.wr(16'hFE08, 8'h00);
  endtask
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    nv_seq(8'h01, a);
    cpu_model_inst.wr(a, d);
    finish_op();
  endtask
  task automatic t_regs();
    rchk(16'hFE08, 8'h00);
    rchk(16'hFE07, 8'h00);
    rchk(16'h1000, 8'h00);
    rchk(16'hFDFF, 8'hFF);
    rchk(16'hFE00, 8'h00);
    rchk(16'hFFFE, 8'hFF);
    $display("test regs done");
  endtask
  task automatic t_interlock();
    cpu_model_inst.wr(16'hFE08, 8'h03);
    rchk(16'hFE08, 8'h00);
    cpu_model_inst.wr(16'hFE08, 8'hF4);
    rchk(16'hFE08, 8'h04);
    cpu_model_inst.wr(16'hFE08, 8'h01);
    cpu_model_inst.wr(16'hFE08, 8'h03);
    rchk(16'hFE08, 8'h01);
    cpu_model_inst.wr(16'hFE08, 8'h00);
    $display("test interlock done");
  endtask
  task automatic t_program();
    nv_seq(8'h01, 16'hE000);
    hchk(1'b1);
    cpu_model_inst.wr(16'hE005, 8'h3C);
    cpu_model_inst.wr(16'hE025, 8'h00);
    finish_op();
    rchk(16'hE005, 8'h3C);
    rchk(16'hE025, 8'hFF);
    rchk(16'hE004, 8'hFF);
    $display("test program done");
  endtask
  task automatic t_erase();
    prog(16'hE045, 8'h5A);
    rchk(16'hE045, 8'h5A);
    // latch in the upper row: whole page must clear
    nv_seq(8'h02, 16'hE060);
    finish_op();
    rchk(16'hE045, 8'hFF);
    rchk(16'hE07F, 8'hFF);
    rchk(16'hE005, 8'h3C);
    $display("test erase done");
  endtask
  task automatic t_protect();
    prog(16'hFF7E, 8'hFE);
    do_reset();
    rchk(16'hFF7E, 8'hFE);
    nv_seq(8'h01, 16'hFFDC);
    hchk(1'b0);
    cpu_model_inst.wr(16'hFE08, 8'h00);
    $display("test protect done");
  endtask
  task automatic t_secure();
    secure <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(16'hE005, 8'h00);
    rchk(16'hFF7E, 8'hFE);
    secure <= 1'b0;
    repeat (4) @(posedge clk);
    rchk(16'hE005, 8'h3C);
    $display("test secure done");
  endtask
  initial begin
    arst_n = 1'b0;
    secure = 1'b0;
    do_reset();
    t_regs();
    t_interlock();
    t_program();
    t_erase();
    t_protect();
    t_secure();
    end_sim();
  end
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule
bind nv_ctrl nv_ctrl_props nv_ctrl_props_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .secure_i(secure_i),
  .rdata_o(rdata_o), .high_voltage_o(high_voltage_o));
